// ### rtl/ddp_engine.sv
// top of the dual wiper serial command engine: link shifter plus core
// assumes a host spi master (mode 0) and a nonvolatile array modelled in
// flip-flops; the analog ladder sits outside and reads the wiper codes
`timescale 1ns/1ns
`default_nettype none
module ddp_engine #(
  parameter int NV_WRITE_TIME = ddp_pkg::NV_WRITE_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  input wire logic write_protect_n_in,
  input wire logic restore_strobe_n_in,
  output logic [9:0] wiper_latch_one_out,
  output logic [9:0] wiper_latch_two_out,
  output logic nv_busy_out
);
  // the busy checker below needs the timer to run for two cycles at least
  if (NV_WRITE_TIME < 2) begin : g_bad_time
    $error("nv write time must be at least two cycles");
  end

  ddp_frame_if frame_bus ();

  ddp_link u_link (
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .frame(frame_bus)
  );

  // synchronisers for the frame event and the pins from outside
  logic [2:0] tog_sync;
  logic [1:0] wp_sync;
  logic [2:0] pr_sync;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_sync <= 3'h0;
      wp_sync <= 2'h0;
      pr_sync <= 3'h7;
    end else begin
      tog_sync <= {tog_sync[1:0], frame_bus.toggle};
      wp_sync <= {wp_sync[0], write_protect_n_in};
      pr_sync <= {pr_sync[1:0], restore_strobe_n_in};
    end
  end
  logic frame_go;
  logic strobe_go;
  logic wp_ok;
  assign frame_go = tog_sync[2] ^ tog_sync[1];
  assign strobe_go = pr_sync[2] & ~pr_sync[1];
  assign wp_ok = wp_sync[1];

  // frame word is stable for many core cycles after the toggle moved
  logic [23:0] word;
  logic [3:0] op;
  logic [3:0] addr;
  logic [15:0] data;
  assign word = frame_bus.word;
  assign op = word[ddp_pkg::OP_MSB:ddp_pkg::OP_LSB];
  assign addr = word[ddp_pkg::ADDR_MSB:ddp_pkg::ADDR_LSB];
  assign data = word[15:0];

  function automatic logic [9:0] ddp_double(input logic [9:0] v);
    if (v[9]) begin
      ddp_double = ddp_pkg::WIPER_FULL;
    end else begin
      ddp_double = {v[8:0], 1'b0};
    end
  endfunction

  function automatic logic [9:0] ddp_inc(input logic [9:0] v);
    if (v == ddp_pkg::WIPER_FULL) begin
      ddp_inc = v;
    end else begin
      ddp_inc = v + 10'h001;
    end
  endfunction

  // nonvolatile array: word 0/1 stored wipers, words 2 to 14 user words, word 15 not writable
  logic [15:0] nv_mem [ddp_pkg::NV_WORDS];
  logic [31:0] nv_timer;
  logic boot_done;
  logic nv_write;
  logic nv_idle;
  assign nv_idle = (nv_timer == 32'h00000000);
  assign nv_busy_out = ~nv_idle;
  // user writes outside the user words are dropped and start no timer
  logic user_addr_ok;
  assign user_addr_ok = addr >= ddp_pkg::ADDR_USER_ONE
    && addr < ddp_pkg::ADDR_USER_ONE + 4'(ddp_pkg::NV_USER_WORDS);
  assign nv_write = frame_go && nv_idle && wp_ok
    && (op == ddp_pkg::DDP_OP_STORE
      || (op == ddp_pkg::DDP_OP_USER_WRITE && user_addr_ok));

  logic [15:0] nv_wdata;
  always_comb begin
    nv_wdata = data;
    if (op == ddp_pkg::DDP_OP_STORE) begin
      nv_wdata = addr[0] ? {6'h00, wiper_latch_two_out}
                         : {6'h00, wiper_latch_one_out};
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < ddp_pkg::NV_WORDS; i++) begin
        nv_mem[i] <= 16'h0200;
      end
    end else if (nv_write) begin
      if (op == ddp_pkg::DDP_OP_STORE) begin
        nv_mem[{3'h0, addr[0]}] <= nv_wdata;
      end else if (user_addr_ok) begin
        nv_mem[addr] <= nv_wdata;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv_timer <= 32'h00000000;
    end else if (nv_write) begin
      nv_timer <= 32'(NV_WRITE_TIME);
    end else if (!nv_idle) begin
      nv_timer <= nv_timer - 32'h00000001;
    end
  end

  // wiper latches
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_done <= 1'b0;
      wiper_latch_one_out <= ddp_pkg::WIPER_RESET;
      wiper_latch_two_out <= ddp_pkg::WIPER_RESET;
    end else if (!boot_done || strobe_go) begin
      boot_done <= 1'b1;
      wiper_latch_one_out <= nv_mem[0][9:0];
      wiper_latch_two_out <= nv_mem[1][9:0];
    end else if (frame_go) begin
      unique case (op)
        ddp_pkg::DDP_OP_WIPER_WRITE: begin
          if (addr == ddp_pkg::ADDR_WIPER_ONE) begin
            wiper_latch_one_out <= data[9:0];
          end else if (addr == ddp_pkg::ADDR_WIPER_TWO) begin
            wiper_latch_two_out <= data[9:0];
          end
        end
        ddp_pkg::DDP_OP_INCREMENT: begin
          if (addr == ddp_pkg::ADDR_WIPER_ONE) begin
            wiper_latch_one_out <= ddp_inc(wiper_latch_one_out);
          end else if (addr == ddp_pkg::ADDR_WIPER_TWO) begin
            wiper_latch_two_out <= ddp_inc(wiper_latch_two_out);
          end
        end
        ddp_pkg::DDP_OP_SHIFT_LEFT: begin
          if (addr == ddp_pkg::ADDR_WIPER_ONE) begin
            wiper_latch_one_out <= ddp_double(wiper_latch_one_out);
          end else if (addr == ddp_pkg::ADDR_WIPER_TWO) begin
            wiper_latch_two_out <= ddp_double(wiper_latch_two_out);
          end
        end
        ddp_pkg::DDP_OP_RESTORE: begin
          if (addr == ddp_pkg::ADDR_WIPER_ONE) begin
            wiper_latch_one_out <= nv_mem[0][9:0];
          end else if (addr == ddp_pkg::ADDR_WIPER_TWO) begin
            wiper_latch_two_out <= nv_mem[1][9:0];
          end
        end
        default: begin
          // nop and the remaining codes leave the latches alone
        end
      endcase
    end
  end

  // reply for the next frame: echo, or prepared readback
  logic [23:0] reply;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reply <= 24'h000000;
    end else if (frame_go) begin
      if (op == ddp_pkg::DDP_OP_NV_READ) begin
        reply <= {word[23:16], nv_mem[addr]};
      end else if (op == ddp_pkg::DDP_OP_WIPER_READ) begin
        reply <= {word[23:16], 6'h00,
          addr[0] ? wiper_latch_two_out : wiper_latch_one_out};
      end else begin
        reply <= word;
      end
    end
  end
  // the reply is only picked up by the link after the next frame starts,
  // well after the few core cycles needed to settle it; on the host
  assign frame_bus.reply = reply;

  a_inc_adds_one: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (boot_done && !strobe_go && frame_go
      && op == ddp_pkg::DDP_OP_INCREMENT && addr == 4'h0
      && wiper_latch_one_out != 10'h3FF)
    |=> wiper_latch_one_out == $past(wiper_latch_one_out) + 10'h001)
    else $error("increment did not add one");
  a_write_loads: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (boot_done && !strobe_go && frame_go
      && op == ddp_pkg::DDP_OP_WIPER_WRITE && addr == 4'h0)
    |=> wiper_latch_one_out == $past(data[9:0]))
    else $error("wiper write lost");
  a_double_sat: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (boot_done && !strobe_go && frame_go
      && op == ddp_pkg::DDP_OP_SHIFT_LEFT && addr == 4'h0
      && wiper_latch_one_out[9])
    |=> wiper_latch_one_out == 10'h3FF)
    else $error("doubling wrapped");
  a_wp_blocks: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    !wp_ok |-> !nv_write)
    else $error("nv write while protected");
  a_busy_blocks: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    nv_write |=> nv_busy_out [*2])
    else $error("nv timer did not start");
  a_echo_reply: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (frame_go && op == ddp_pkg::DDP_OP_NOP) |=> reply == $past(word))
    else $error("echo wrong");
  a_nop_keeps: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    (boot_done && !strobe_go && frame_go && op == ddp_pkg::DDP_OP_NOP)
    |=> $stable(wiper_latch_one_out) && $stable(wiper_latch_two_out))
    else $error("nop changed a wiper");
  a_strobe_restore: assert property (@(posedge clock_in)
    disable iff (!reset_n_in)
    strobe_go |=> wiper_latch_two_out == $past(nv_mem[1][9:0]))
    else $error("restore strobe ignored");
  c_store: cover property (@(posedge clock_in) nv_write);
  c_readback: cover property (@(posedge clock_in)
    frame_go && op == ddp_pkg::DDP_OP_WIPER_READ);
  c_strobe: cover property (@(posedge clock_in) strobe_go);
  c_deferred: cover property (@(posedge clock_in) frame_go && !nv_idle);
endmodule
`default_nettype wire

// ### rtl/ddp_frame_if.sv
// carries one finished frame from the link domain to the core domain
// assumes frame word is stable whenever the toggle has changed
`timescale 1ns/1ns
`default_nettype none
interface ddp_frame_if;
  logic [23:0] word;
  logic toggle;
  logic [23:0] reply;
  modport link (output word, output toggle, input reply);
  modport core (input word, input toggle, output reply);
endinterface
`default_nettype wire

// ### rtl/ddp_link.sv
// serial shifter on the link clock: captures frames, shifts the reply out
// assumes the host keeps the serial clock low at idle and samples on rise
`timescale 1ns/1ns
`default_nettype none
module ddp_link (
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  ddp_frame_if.link frame
);
  logic [23:0] shift_in;
  logic [23:0] shift_out;
  logic [4:0] count;
  logic loaded;
  // counts past 24 so that an overlong frame is dropped, not taken
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      count <= 5'h00;
    end else if (count != 5'h19) begin
      count <= count + 5'h01;
    end
  end
  always_ff @(posedge sclk_in) begin
    shift_in <= {shift_in[22:0], sdi_in};
  end
  // reply msb goes out before the first fall; the rest loads on that fall
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      shift_out <= 24'h000000;
      loaded <= 1'b0;
    end else if (!loaded) begin
      shift_out <= {frame.reply[22:0], 1'b0};
      loaded <= 1'b1;
    end else begin
      shift_out <= {shift_out[22:0], 1'b0};
    end
  end
  // the first reply bit is presented straight from the core's reply
  assign sdo_out = loaded ? shift_out[23] : frame.reply[23];
  // frame is handed over on chip select rising; toggle carries the event
  always_ff @(posedge cs_n_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame.word <= 24'h000000;
      frame.toggle <= 1'b0;
    end else if (count == 5'h18) begin
      frame.word <= shift_in;
      frame.toggle <= ~frame.toggle;
    end
  end
endmodule
`default_nettype wire

// ### rtl/ddp_pkg.sv
// package for the dual wiper serial command engine
// assumes a 24-bit msb-first frame that executes when chip select rises
package ddp_pkg;
  localparam int FRAME_BITS = 24;
  localparam int WIPER_BITS = 10;
  localparam int DATA_BITS = 16;
  localparam int NV_WORDS = 16;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam logic [9:0] WIPER_RESET = 10'h200;
  localparam logic [9:0] WIPER_FULL = 10'h3FF;
  localparam logic [3:0] ADDR_WIPER_ONE = 4'h0;
  localparam logic [3:0] ADDR_WIPER_TWO = 4'h1;
  localparam logic [3:0] ADDR_USER_ONE = 4'h2;
  localparam logic [3:0] ADDR_USER_TWO = 4'h3;
  localparam int NV_USER_WORDS = 13;
  // nonvolatile write time, in microseconds, and its cycle count at 125 MHz
  localparam int NV_WRITE_US = 26;
  localparam int CLK_MHZ = 125;
  localparam int NV_WRITE_CYCLES = NV_WRITE_US * CLK_MHZ;
  typedef enum logic [3:0] {
    DDP_OP_NOP = 4'h0,
    DDP_OP_RESTORE = 4'h1,
    DDP_OP_STORE = 4'h2,
    DDP_OP_USER_WRITE = 4'h3,
    DDP_OP_NV_READ = 4'h9,
    DDP_OP_WIPER_READ = 4'hA,
    DDP_OP_WIPER_WRITE = 4'hB,
    DDP_OP_SHIFT_LEFT = 4'hC,
    DDP_OP_INCREMENT = 4'hE
  } ddp_op_t;
endpackage

// ### test/ddp_host_model.sv
// spi host model that clocks whole frames into the command engine
// assumes mode 0: serial clock idles low, both sides sample on its rise
`timescale 1ns/1ns
`default_nettype none
module ddp_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // serial clock runs only inside a frame, 125 ns period
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    cs_n_out = 1'b0;
    sdi_out = tx[23];
    #63;
    for (int i = 23; i >= 0; i--) begin
      sclk_out = 1'b1;
      rx[i] = sdo_in;
      #62;
      sclk_out = 1'b0;
      if (i > 0) sdi_out = tx[i-1];
      #63;
    end
    cs_n_out = 1'b1;
    // released line flips so a stale bit never passes for data
    sdi_out = ~sdi_out;
    #400;
  endtask
endmodule
`default_nettype wire

// ### test/test_dual_digipot_serial_command_engine.sv
// self-checking bench for the dual wiper serial command engine
// assumes the host model owns the serial pins and frames never overlap
`timescale 1ns/1ns
`default_nettype none
module test_dual_digipot_serial_command_engine;
  logic clock_in;
  logic reset_n_in;
  logic write_protect_n;
  logic restore_n;
  wire logic sclk, cs_n, sdi, sdo, busy;
  wire logic [9:0] w_one, w_two;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'h7F7EEBC0;
  int w[2];
  int nv[16];
  logic [23:0] reply;
  bit reply_ok = 1'b0;
  // the write timer outlasts one frame but not two
  bit wrote_prev = 1'b0;
  bit busy_exp = 1'b0;
  int ops[9] = '{4'hB, 4'hE, 4'hC, 4'hA, 4'h9, 4'h1, 4'h0, 4'h3, 4'h2};

  ddp_engine #(.NV_WRITE_TIME(600)) dut_u (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo),
    .write_protect_n_in(write_protect_n), .restore_strobe_n_in(restore_n),
    .wiper_latch_one_out(w_one), .wiper_latch_two_out(w_two),
    .nv_busy_out(busy)
  );
  ddp_host_model host_u (
    .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo)
  );

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic chk(input string name, input logic [23:0] exp,
                     input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_state;
    chk("wiper one", 24'(w[0]), {14'h0, w_one});
    chk("wiper two", 24'(w[1]), {14'h0, w_two});
    chk("nv busy", 24'(busy_exp), {23'h0, busy});
  endtask

  // one frame, then the reference model steps and both are compared
  task automatic xfer(input logic [23:0] tx);
    logic [23:0] rx;
    int a;
    bit nv_ok;
    bit wrote_now;
    host_u.frame(tx, rx);
    a = tx[19:16];
    nv_ok = write_protect_n && !wrote_prev;
    wrote_now = 1'b0;
    if (reply_ok) chk("reply", reply, rx);
    reply = tx;
    reply_ok = 1'b1;
    case (tx[23:20])
      4'hB: w[a % 2] = tx[9:0];
      4'hE: w[a % 2] = (w[a % 2] == 1023) ? 1023 : w[a % 2] + 1;
      4'hC: w[a % 2] = (w[a % 2] > 511) ? 1023 : w[a % 2] * 2;
      4'h2: if (nv_ok) begin
        nv[a % 2] = w[a % 2];
        wrote_now = 1'b1;
      end
      4'h1: w[a % 2] = nv[a % 2];
      4'h3: if (nv_ok && a > 1 && a < 15) begin
        nv[a] = tx[15:0];
        wrote_now = 1'b1;
      end
      4'h9: reply[15:0] = nv[a];
      4'hA: reply[15:0] = w[a % 2];
      default: ;
    endcase
    busy_exp = wrote_now || wrote_prev;
    wrote_prev = wrote_now;
    check_state();
  endtask

  task automatic strobe_restore;
    @(posedge clock_in);
    restore_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    restore_n <= 1'b1;
    repeat (10) @(posedge clock_in);
    w[0] = nv[0];
    w[1] = nv[1];
    check_state();
  endtask

  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end

  initial begin
    int op;
    int a;
    logic [31:0] r;
    // starts high so the link's asynchronous reset sees a real falling edge
    reset_n_in = 1'b1;
    write_protect_n = 1'b1;
    restore_n = 1'b1;
    w = '{512, 512};
    for (int i = 0; i < 16; i++) nv[i] = 512;
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    check_state();
    xfer(24'hB00100);
    xfer(24'hE05A5A);
    xfer(24'hE0A5A5);
    xfer(24'h200000);
    @(posedge clock_in);
    write_protect_n <= 1'b0;
    xfer(24'hB00055);
    xfer(24'h200000);
    xfer(24'h321234);
    xfer(24'h100000);
    @(posedge clock_in);
    write_protect_n <= 1'b1;
    xfer(24'hB10333);
    strobe_restore();
    xfer(24'hC00000);
    xfer(24'hC10000);
    xfer(24'hB00200);
    xfer(24'hC00000);
    xfer(24'hA00000);
    xfer(24'hF0FFFF);
    xfer(24'h32AAAA);
    xfer(24'h331111);
    xfer(24'h335555);
    xfer(24'h92FFFF);
    xfer(24'h001234);
    xfer(24'h930000);
    xfer(24'h000000);
    for (int n = 0; n < 20; n++) begin
      r = $random(seed);
      op = ops[r[31:28] % 9];
      a = (op == 9 || op == 3) ? r[17:16] : r[16];
      if (op == 11) r[15:10] = 6'h0;
      @(posedge clock_in);
      write_protect_n <= r[27] | r[26];
      xfer({op[3:0], a[3:0], r[15:0]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
